// ===== core/css_pkg.sv
// Constants and types for the 16-bit card socket strobe control block
// Functional notes
// R1: Low byte-lane enable asserted for even address bytes during a transfer.
// R2: High byte-lane enable asserted for odd address bytes during a transfer.
// R3: Card acknowledges only I/O reads it can answer at current address.
// R4: With DMA configured, input acknowledge may serve as card DMA request.
// R5: I/O read strobe asserted during host I/O reads.
// R6: During DMA card-to-memory, I/O read strobe acts as DMA write strobe.
// R7: I/O write strobe driven low during host I/O writes.
// R8: During DMA memory-to-card, I/O write strobe is asserted.
// R9: Output enable driven low during host memory reads.
// R10: Output enable signals terminal count in DMA write operations.
// R11: Ready/interrupt input means ready only in memory-only interface mode.
// R12: Memory card holds ready low while busy with previous write.
// R13: Memory card drives ready high when it can accept a command.
// R14: In I/O mode, card interrupt request is passed to the host.
// R15: Card interrupt request is active low, high when idle.
// R16: Wait input stretches the cycle; completion delayed until released.
// R17: Attribute select high for common memory, asserted for attribute or I/O.
// R18: In DMA, attribute select acts as DMA acknowledge with I/O strobe.
// R19: Write enable signals terminal count in DMA read operations.
// R20: Asynchronous card inputs are synchronised before use.
package css_pkg;

  // Cycle kinds requested by the host side
  localparam logic [2:0] CYC_MEM_RD  = 3'h0;
  localparam logic [2:0] CYC_MEM_WR  = 3'h1;
  localparam logic [2:0] CYC_IO_RD   = 3'h2;
  localparam logic [2:0] CYC_IO_WR   = 3'h3;
  localparam logic [2:0] CYC_DMA_RD  = 3'h4;
  localparam logic [2:0] CYC_DMA_WR  = 3'h5;

  // Timing at a 20 MHz clock
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SETUP_NS       = 60;
  localparam int STROBE_NS      = 165;
  localparam int HOLD_NS        = 30;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 4;

  typedef enum logic [2:0] {
    CSS_IDLE   = 3'b000,
    CSS_SETUP  = 3'b001,
    CSS_STROBE = 3'b010,
    CSS_WAIT   = 3'b011,
    CSS_HOLD   = 3'b100
  } css_state_e;

  // Cycle kinds that read data from the card
  function automatic logic css_is_read(input logic [2:0] kind);
    return (kind == CYC_MEM_RD) || (kind == CYC_IO_RD) || (kind == CYC_DMA_WR);
  endfunction : css_is_read

  function automatic logic css_is_dma(input logic [2:0] kind);
    return (kind == CYC_DMA_RD) || (kind == CYC_DMA_WR);
  endfunction : css_is_dma

endpackage : css_pkg

// ===== core/css_sync.sv
// Two-flop synchroniser for one card input
`timescale 1ns/1ps
module css_sync
  import css_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Data
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule : css_sync

// ===== core/css_status.sv
// Routing of the shared ready/interrupt and acknowledge card inputs
`timescale 1ns/1ps
module css_status
  import css_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Configuration
  input  wire logic memory_only_mode,
  input  wire logic dma_enable,
  // Synchronised card inputs
  input  wire logic ready_irq_sync,
  input  wire logic ack_sync_n,
  // Host side
  output logic      card_ready,
  output logic      host_irq,
  output logic      dma_request,
  output logic      io_read_ack
);

  logic ready_ff;
  logic irq_ff;
  logic dreq_ff;
  logic ack_ff;
  logic nxt_ready;
  logic nxt_irq;
  logic nxt_dreq;
  logic nxt_ack;

  always_comb begin
    // R11 ready only memory-only
    nxt_ready = memory_only_mode & ready_irq_sync;
    // R14 pass interrupt to host
    // R15 active low request
    nxt_irq   = ~memory_only_mode & ~ready_irq_sync;
    // R4 acknowledge as DMA request
    nxt_dreq  = dma_enable & ~ack_sync_n;
    // R3 acknowledge for I/O read
    nxt_ack   = ~dma_enable & ~ack_sync_n;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_ff <= 1'b0;
      irq_ff   <= 1'b0;
      dreq_ff  <= 1'b0;
      ack_ff   <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
      irq_ff   <= nxt_irq;
      dreq_ff  <= nxt_dreq;
      ack_ff   <= nxt_ack;
    end
  end

  assign card_ready  = ready_ff;
  assign host_irq    = irq_ff;
  assign dma_request = dreq_ff;
  assign io_read_ack = ack_ff;

endmodule : css_status

// ===== core/css_top.sv
// Strobe and byte-lane control for one 16-bit card socket
`timescale 1ns/1ps
module css_top
  import css_pkg::*;
#(
  parameter int SETUP_CYCLES  = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int HOLD_CYCLES   = HOLD_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Configuration
  input  wire logic       memory_only_mode,
  input  wire logic       dma_enable,
  // Host cycle request
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire logic [2:0] req_kind,
  input  wire logic       req_addr0,
  input  wire logic       req_wide,
  input  wire logic       req_attr,
  input  wire logic       req_last,
  output logic            cyc_done,
  // Host status
  output logic            card_ready,
  output logic            host_irq,
  output logic            dma_request,
  output logic            io_read_ack,
  // Card outputs
  output logic            even_byte_enable_n,
  output logic            odd_byte_enable_n,
  output logic            output_enable_n,
  output logic            write_enable_n,
  output logic            io_read_strobe_n,
  output logic            io_write_strobe_n,
  output logic            attr_select_n,
  // Card inputs
  input  wire logic       input_acknowledge_n,
  input  wire logic       card_ready_irq,
  input  wire logic       card_wait_n
);

  // R20 synchronise card inputs
  logic ack_sync_n;
  logic rdy_sync;
  logic wait_sync_n;

  css_sync #(.RESET_VAL(1'b1)) u_sync_ack (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (input_acknowledge_n),
    .sync_out (ack_sync_n)
  );

  css_sync #(.RESET_VAL(1'b1)) u_sync_rdy (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (card_ready_irq),
    .sync_out (rdy_sync)
  );

  css_sync #(.RESET_VAL(1'b1)) u_sync_wait (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (card_wait_n),
    .sync_out (wait_sync_n)
  );

  css_status u_status (
    .clk              (clk),
    .rst_b            (rst_b),
    .memory_only_mode (memory_only_mode),
    .dma_enable       (dma_enable),
    .ready_irq_sync   (rdy_sync),
    .ack_sync_n       (ack_sync_n),
    .card_ready       (card_ready),
    .host_irq         (host_irq),
    .dma_request      (dma_request),
    .io_read_ack      (io_read_ack)
  );

  // Cycle sequencer state
  css_state_e           state_ff;
  css_state_e           nxt_state;
  logic [CNT_W-1:0]     cnt_ff;
  logic [CNT_W-1:0]     nxt_cnt;
  logic [2:0]           kind_ff;
  logic [2:0]           nxt_kind;
  logic                 addr0_ff;
  logic                 nxt_addr0;
  logic                 wide_ff;
  logic                 nxt_wide;
  logic                 attr_ff;
  logic                 nxt_attr;
  logic                 last_ff;
  logic                 nxt_last;
  logic                 done_ff;
  logic                 nxt_done;

  // Card output registers
  logic even_ff;
  logic odd_ff;
  logic oe_ff;
  logic we_ff;
  logic io_read_strobe_n_ff;
  logic io_write_strobe_n_ff;
  logic reg_ff;
  logic nxt_even;
  logic nxt_odd;
  logic nxt_oe;
  logic nxt_we;
  logic nxt_io_read_strobe_n;
  logic nxt_io_write_strobe_n;
  logic nxt_reg;

  logic active;
  logic strobing;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_kind  = kind_ff;
    nxt_addr0 = addr0_ff;
    nxt_wide  = wide_ff;
    nxt_attr  = attr_ff;
    nxt_last  = last_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      CSS_IDLE: begin
        if (req_valid) begin
          nxt_kind  = req_kind;
          nxt_addr0 = req_addr0;
          nxt_wide  = req_wide;
          nxt_attr  = req_attr;
          nxt_last  = req_last;
          nxt_cnt   = CNT_W'(SETUP_CYCLES - 1);
          nxt_state = CSS_SETUP;
        end
      end
      CSS_SETUP: begin
        if (cnt_ff == '0) begin
          nxt_cnt   = CNT_W'(STROBE_CYCLES - 1);
          nxt_state = CSS_STROBE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      CSS_STROBE: begin
        if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end else if (!wait_sync_n) begin
          // R16 stretch while wait held
          nxt_state = CSS_WAIT;
        end else begin
          nxt_cnt   = CNT_W'(HOLD_CYCLES - 1);
          nxt_state = CSS_HOLD;
        end
      end
      CSS_WAIT: begin
        // R16 complete after release
        if (wait_sync_n) begin
          nxt_cnt   = CNT_W'(HOLD_CYCLES - 1);
          nxt_state = CSS_HOLD;
        end
      end
      CSS_HOLD: begin
        if (cnt_ff == '0) begin
          nxt_done  = 1'b1;
          nxt_state = CSS_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = CSS_IDLE;
      end
    endcase
  end

  // Card lines follow the next state so they change together with it
  assign active   = (nxt_state != CSS_IDLE);
  assign strobing = (nxt_state == CSS_STROBE) || (nxt_state == CSS_WAIT);

  // Byte lane in use: wide cycles take both lanes, narrow ones the addressed lane
  function automatic logic lane_on(input logic addr0, input logic wide, input logic odd_lane);
    return wide || (addr0 == odd_lane);
  endfunction : lane_on

  // Cycle kinds that address the card's I/O space
  function automatic logic is_io(input logic [2:0] kind);
    return (kind == CYC_IO_RD) || (kind == CYC_IO_WR);
  endfunction : is_io

  // Cycle kinds strobed on the I/O read line
  function automatic logic on_read_line(input logic [2:0] kind);
    return (kind == CYC_IO_RD) || (kind == CYC_DMA_WR);
  endfunction : on_read_line

  // Cycle kinds strobed on the I/O write line
  function automatic logic on_write_line(input logic [2:0] kind);
    return (kind == CYC_IO_WR) || (kind == CYC_DMA_RD);
  endfunction : on_write_line

  always_comb begin
    // Idle: every card line deasserted
    nxt_even = 1'b1;
    nxt_odd  = 1'b1;
    nxt_reg  = 1'b1;
    nxt_oe   = 1'b1;
    nxt_we   = 1'b1;
    nxt_io_read_strobe_n = 1'b1;
    nxt_io_write_strobe_n = 1'b1;
    if (active) begin
      // R1 even byte lane
      if (lane_on(nxt_addr0, nxt_wide, 1'b0)) begin
        nxt_even = 1'b0;
      end
      // R2 odd byte lane
      if (lane_on(nxt_addr0, nxt_wide, 1'b1)) begin
        nxt_odd = 1'b0;
      end
      // R17 attribute or I/O space
      if (nxt_attr || is_io(nxt_kind)) begin
        nxt_reg = 1'b0;
      end
      // R18 DMA acknowledge on attribute select
      if (css_is_dma(nxt_kind)) begin
        nxt_reg = !dma_enable;
      end
    end
    if (strobing) begin
      // R9 output enable for memory reads
      if (nxt_kind == CYC_MEM_RD) begin
        nxt_oe = 1'b0;
      end
      // R10 terminal count on output enable
      if (nxt_kind == CYC_DMA_WR && nxt_last) begin
        nxt_oe = 1'b0;
      end
      // Write enable for memory writes
      if (nxt_kind == CYC_MEM_WR) begin
        nxt_we = 1'b0;
      end
      // R19 terminal count on write enable
      if (nxt_kind == CYC_DMA_RD && nxt_last) begin
        nxt_we = 1'b0;
      end
      // R5 I/O read strobe
      // R6 DMA write strobe on I/O read
      nxt_io_read_strobe_n = !on_read_line(nxt_kind);
      // R7 I/O write strobe low
      // R8 DMA read strobe on I/O write
      nxt_io_write_strobe_n = !on_write_line(nxt_kind);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= CSS_IDLE;
      cnt_ff   <= '0;
      kind_ff  <= CYC_MEM_RD;
      addr0_ff <= 1'b0;
      wide_ff  <= 1'b0;
      attr_ff  <= 1'b0;
      last_ff  <= 1'b0;
      done_ff  <= 1'b0;
      even_ff  <= 1'b1;
      odd_ff   <= 1'b1;
      oe_ff    <= 1'b1;
      we_ff    <= 1'b1;
      io_read_strobe_n_ff  <= 1'b1;
      io_write_strobe_n_ff  <= 1'b1;
      reg_ff   <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      kind_ff  <= nxt_kind;
      addr0_ff <= nxt_addr0;
      wide_ff  <= nxt_wide;
      attr_ff  <= nxt_attr;
      last_ff  <= nxt_last;
      done_ff  <= nxt_done;
      even_ff  <= nxt_even;
      odd_ff   <= nxt_odd;
      oe_ff    <= nxt_oe;
      we_ff    <= nxt_we;
      io_read_strobe_n_ff  <= nxt_io_read_strobe_n;
      io_write_strobe_n_ff  <= nxt_io_write_strobe_n;
      reg_ff   <= nxt_reg;
    end
  end

  assign req_ready          = (state_ff == CSS_IDLE);
  assign cyc_done           = done_ff;
  assign even_byte_enable_n = even_ff;
  assign odd_byte_enable_n  = odd_ff;
  assign output_enable_n    = oe_ff;
  assign write_enable_n     = we_ff;
  assign io_read_strobe_n   = io_read_strobe_n_ff;
  assign io_write_strobe_n  = io_write_strobe_n_ff;
  assign attr_select_n      = reg_ff;

endmodule : css_top

// ===== sim/css_card_model.sv
// Behavioural 16-bit card at the far side of the socket
`timescale 1ns/1ps
module css_card_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Socket lines
  input  wire logic       io_read_strobe_n,
  output logic            input_acknowledge_n,
  output logic            card_ready_irq,
  output logic            card_wait_n,
  // Scenario controls
  input  wire logic       mem_only,
  input  wire logic       busy,
  input  wire logic       irq_req,
  input  wire logic       dma_req,
  input  wire logic [3:0] wait_cyc
);
  logic [3:0] wait_ff;
  logic       rd_ff;
  assign input_acknowledge_n = !(dma_req || !io_read_strobe_n);
  assign card_ready_irq = mem_only ? !busy : !irq_req;
  assign card_wait_n = (wait_ff == 4'h0);
  always_ff @(posedge clk) begin
    rd_ff <= io_read_strobe_n;
    if (!rst_b) wait_ff <= 4'h0;
    else if (rd_ff && !io_read_strobe_n) wait_ff <= wait_cyc;
    else if (wait_ff != 4'h0) wait_ff <= wait_ff - 4'h1;
  end
endmodule : css_card_model

// ===== sim/css_top_asserts.sv
// Port-level assertions for the card socket strobe control
`timescale 1ns/1ps
module css_top_asserts
  import css_pkg::*;
#(
  parameter int SETUP_CYCLES  = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int HOLD_CYCLES   = HOLD_CYC
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // Host side
  input wire logic       memory_only_mode,
  input wire logic       dma_enable,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [2:0] req_kind,
  input wire logic       req_addr0,
  input wire logic       req_wide,
  input wire logic       req_attr,
  input wire logic       req_last,
  input wire logic       cyc_done,
  input wire logic       card_ready,
  input wire logic       host_irq,
  input wire logic       dma_request,
  input wire logic       io_read_ack,
  // Card lines
  input wire logic       even_byte_enable_n,
  input wire logic       odd_byte_enable_n,
  input wire logic       output_enable_n,
  input wire logic       write_enable_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic       attr_select_n,
  input wire logic       input_acknowledge_n,
  input wire logic       card_ready_irq,
  input wire logic       card_wait_n
);
  localparam int STB = SETUP_CYCLES + 2;
  logic take;
  assign take = req_valid && req_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take(logic [2:0] k);
    take && req_kind == k;
  endsequence
  a_even_lane: assert property (take && !req_wide && !req_addr0 |-> ##2 !even_byte_enable_n)
    else $error("even lane not enabled");
  a_odd_lane: assert property (take && !req_wide && req_addr0 |-> ##2 !odd_byte_enable_n)
    else $error("odd lane not enabled");
  a_io_read: assert property (s_take(CYC_IO_RD) |-> ##STB !io_read_strobe_n)
    else $error("read strobe missing");
  a_dma_write: assert property (s_take(CYC_DMA_WR) |-> ##STB !io_read_strobe_n)
    else $error("dma write strobe missing");
  a_io_write: assert property (s_take(CYC_IO_WR) |-> ##STB !io_write_strobe_n)
    else $error("write strobe missing");
  a_dma_read: assert property (s_take(CYC_DMA_RD) |-> ##STB !io_write_strobe_n)
    else $error("dma read strobe missing");
  a_mem_read: assert property (s_take(CYC_MEM_RD) |-> ##STB !output_enable_n)
    else $error("output enable missing");
  a_tc_oe: assert property (s_take(CYC_DMA_WR) ##0 req_last |-> ##STB !output_enable_n)
    else $error("terminal count on oe missing");
  a_tc_we: assert property (s_take(CYC_DMA_RD) ##0 req_last |-> ##STB !write_enable_n)
    else $error("terminal count on we missing");
  a_common_attr: assert property (s_take(CYC_MEM_RD) ##0 !req_attr |-> ##2 attr_select_n)
    else $error("attribute select on common access");
  a_dma_ack: assert property (take && dma_enable && req_kind[2] |-> ##2 !attr_select_n)
    else $error("dma acknowledge missing");
  a_wait_hold: assert property ((!io_read_strobe_n && !card_wait_n) [*4] |=> !io_read_strobe_n)
    else $error("strobe ended during wait");
  a_done_time: assert property (take ##1 card_wait_n [*7] |=> cyc_done)
    else $error("cycle completion late");
  a_ready_mode: assert property (!memory_only_mode |=> !card_ready)
    else $error("ready outside memory mode");
  a_busy_seen: assert property ((memory_only_mode && !card_ready_irq) [*4] |-> !card_ready)
    else $error("busy card reported ready");
  a_ready_seen: assert property ((memory_only_mode && card_ready_irq) [*4] |-> card_ready)
    else $error("ready not reported");
  a_irq_pass: assert property ((!memory_only_mode && !card_ready_irq) [*4] |-> host_irq)
    else $error("interrupt not passed");
  a_dma_req: assert property ((dma_enable && !input_acknowledge_n) [*4] |-> dma_request)
    else $error("dma request not passed");
endmodule : css_top_asserts

bind css_top css_top_asserts #(
  .SETUP_CYCLES(SETUP_CYCLES),
  .STROBE_CYCLES(STROBE_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES)
) u_chk (.clk, .rst_b, .memory_only_mode, .dma_enable, .req_valid, .req_ready, .req_kind,
  .req_addr0, .req_wide, .req_attr, .req_last, .cyc_done, .card_ready, .host_irq, .dma_request,
  .io_read_ack, .even_byte_enable_n, .odd_byte_enable_n, .output_enable_n, .write_enable_n,
  .io_read_strobe_n, .io_write_strobe_n, .attr_select_n, .input_acknowledge_n,
  .card_ready_irq, .card_wait_n);

// ===== sim/tb_card16_socket_strobe_control.sv
// Self-checking bench for the card socket strobe control
`timescale 1ns/1ps
module tb_card16_socket_strobe_control;
  import css_pkg::*;
  logic        clk, rst_b, memory_only_mode, dma_enable, req_valid, req_ready, cyc_done;
  logic [2:0]  req_kind, k;
  logic        req_addr0, req_wide, req_attr, req_last;
  logic        card_ready, host_irq, dma_request, io_read_ack;
  logic        even_byte_enable_n, odd_byte_enable_n, output_enable_n, write_enable_n;
  logic        io_read_strobe_n, io_write_strobe_n, attr_select_n;
  logic        input_acknowledge_n, card_ready_irq, card_wait_n;
  logic        busy, irq_req, dma_req;
  logic [3:0]  wait_cyc;
  logic [31:0] lfsr;
  int          error_cnt, tests_run, lat;

  css_top u_dut (.clk, .rst_b, .memory_only_mode, .dma_enable, .req_valid, .req_ready,
    .req_kind, .req_addr0, .req_wide, .req_attr, .req_last, .cyc_done, .card_ready, .host_irq,
    .dma_request, .io_read_ack, .even_byte_enable_n, .odd_byte_enable_n, .output_enable_n,
    .write_enable_n, .io_read_strobe_n, .io_write_strobe_n, .attr_select_n,
    .input_acknowledge_n, .card_ready_irq, .card_wait_n);
  css_card_model u_card (.clk, .rst_b, .io_read_strobe_n, .input_acknowledge_n,
    .card_ready_irq, .card_wait_n, .mem_only(memory_only_mode), .busy, .irq_req, .dma_req,
    .wait_cyc);

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // Active-low {oe, we, read, write} expected in the strobe phase
  function automatic logic [3:0] exp_str(input logic [2:0] c, input logic l);
    return ~{c == CYC_MEM_RD || (c == CYC_DMA_WR && l), c == CYC_MEM_WR || (c == CYC_DMA_RD && l),
      c == CYC_IO_RD || c == CYC_DMA_WR, c == CYC_IO_WR || c == CYC_DMA_RD};
  endfunction : exp_str

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic do_cyc(input logic [2:0] c, input logic a, w, at, l);
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind  <= c;
    req_addr0 <= a;
    req_wide  <= w;
    req_attr  <= at;
    req_last  <= l;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (SETUP_CYC + 2) @(negedge clk);
    chk("lanes", {2'b0, w ? 2'b00 : (a ? 2'b10 : 2'b01)},
      {2'b0, even_byte_enable_n, odd_byte_enable_n});
    chk("strobes", exp_str(c, l), {output_enable_n, write_enable_n, io_read_strobe_n,
      io_write_strobe_n});
    chk("attr", {3'b0, c[2] ? !dma_enable : !(at || c == CYC_IO_RD || c == CYC_IO_WR)},
      {3'b0, attr_select_n});
    chk("ready while busy", 4'h0, {3'b0, req_ready});
    lat = 0;
    while (cyc_done !== 1'b1 && lat < 60) begin
      @(negedge clk);
      lat++;
    end
    chk("done", 4'h1, {3'b0, cyc_done});
  endtask : do_cyc

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    {rst_b, memory_only_mode, dma_enable, req_valid, req_kind, req_addr0} = '0;
    {req_wide, req_attr, req_last, busy, irq_req, dma_req, wait_cyc} = '0;
    lfsr = 32'h8635;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    dma_enable <= 1'b1;
    for (int i = 0; i < 6; i++) do_cyc(3'(i), i[0], i[1], 1'b0, 1'b1);
    $display("test kinds done");
    for (int i = 0; i < 30; i++) begin
      lfsr = lfsr_next(lfsr);
      k = lfsr[2:0] > 3'h5 ? lfsr[2:0] - 3'h4 : lfsr[2:0];
      dma_enable <= lfsr[8];
      do_cyc(k, lfsr[4], lfsr[5], lfsr[6], lfsr[7]);
    end
    $display("test random done");
    wait_cyc <= 4'h5;
    do_cyc(CYC_IO_RD, 1'b0, 1'b0, 1'b0, 1'b0);
    chk("stretched", 4'h1, {3'b0, lat > 5});
    wait_cyc <= 4'h0;
    $display("test wait done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      memory_only_mode <= i[0];
      busy <= i[1];
      irq_req <= i[1];
      dma_enable <= i[2];
      dma_req <= i[3];
      repeat (5) @(negedge clk);
      chk("status", {i[0] & !i[1], !i[0] & i[1], i[2] & i[3], !i[2] & i[3]},
        {card_ready, host_irq, dma_request, io_read_ack});
    end
    $display("test status done");
    close_out();
  end
endmodule : tb_card16_socket_strobe_control
